// *** core/io_module_command_parser.sv ***
// Purpose: Parses Modbus multi-write requests and character commands, frames replies.
// Assumes: proto_ascii is steady over a frame; rx.last marks a Modbus frame end.
// Notes: Model number and version text are parameters with arbitrary defaults.
`timescale 1ns/1ps
`default_nettype none

module io_module_command_parser
    import io_cmd_pkg::*;
#(
    parameter logic [7:0] STATION = MY_ADDR,
    parameter logic [15:0] MODEL_ID = 16'h1234, // Arbitrary value
    parameter logic [31:0] FW_TEXT = 32'h312E_3030 // Arbitrary value
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic proto_ascii,
    input wire byte_beat_t rx,
    output logic rx_ready,
    output byte_beat_t tx,
    input wire logic tx_ready,
    output coil_wr_t coil_wr,
    output reg_wr_t reg_wr,
    output logic [15:0] aux_flags
);

    logic tx_busy;
    logic resp_start;
    logic [8*RESP_DEPTH-1:0] resp_vec;
    logic [3:0] resp_len;

    // Stall requests while a reply drains; no reply is ever overwritten
    assign rx_ready = !tx_busy;
    wire rx_fire = rx.valid && rx_ready;
    wire mb_fire = rx_fire && !proto_ascii;
    wire as_fire = rx_fire && proto_ascii;

    // ------------------------------------------------------------
    // Modbus multi-write path
    // ------------------------------------------------------------
    mb_state_t st_r, st_nxt;
    logic [7:0] func_r;
    logic [15:0] sa_r;
    logic [15:0] qty_r;
    logic [7:0] dcnt_r;
    logic [15:0] rem_r;
    logic [15:0] waddr_r;
    logic [7:0] hi_r;
    logic ph_r;

    wire is_coils = (func_r == FC_COILS);
    wire [16:0] need_coil = 17'(({1'b0, qty_r} + 17'd7) >> 3);
    wire [16:0] need_reg = {qty_r, 1'b0};
    // A zero quantity never matches, so empty writes are dropped too
    wire bc_ok = (qty_r != 16'h0000) &&
        ({9'h000, rx.data} == (is_coils ? need_coil : need_reg));
    wire data_beat = mb_fire && (st_r == M_DATA) && (dcnt_r != 8'h00);
    wire [7:0] coil_mask = (rem_r >= 16'd8) ? 8'hFF : ~(8'hFF << rem_r[2:0]);
    wire [15:0] coil_step = (rem_r >= 16'd8) ? 16'd8 : rem_r;
    wire mb_done = data_beat && rx.last && (dcnt_r == 8'h01);

    // Header walk; frame end always returns to the start
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            M_ADDR: st_nxt = (rx.data == STATION) ? M_FUNC : M_SKIP;
            M_FUNC: st_nxt = (rx.data == FC_COILS || rx.data == FC_REGS) ? M_SAH : M_SKIP;
            M_SAH: st_nxt = M_SAL;
            M_SAL: st_nxt = M_QH;
            M_QH: st_nxt = M_QL;
            M_QL: st_nxt = M_BC;
            M_BC: st_nxt = bc_ok ? M_DATA : M_SKIP;
            M_DATA: st_nxt = (dcnt_r == 8'h00) ? M_SKIP : M_DATA;
            M_SKIP: st_nxt = M_SKIP;
            default: st_nxt = M_SKIP;
        endcase
        if (rx.last)
            st_nxt = M_ADDR;
    end

    // Header fields, high byte first
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= M_ADDR;
            func_r <= 8'h00;
            sa_r <= 16'h0000;
            qty_r <= 16'h0000;
        end
        else if (mb_fire)
        begin
            st_r <= st_nxt;
            if (st_r == M_FUNC) func_r <= rx.data;
            if (st_r == M_SAH) sa_r[15:8] <= rx.data;
            if (st_r == M_SAL) sa_r[7:0] <= rx.data;
            if (st_r == M_QH) qty_r[15:8] <= rx.data;
            if (st_r == M_QL) qty_r[7:0] <= rx.data;
        end
    end

    // Data walk: count bytes, coils left and next target address
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dcnt_r <= 8'h00;
            rem_r <= 16'h0000;
            waddr_r <= 16'h0000;
            hi_r <= 8'h00;
            ph_r <= 1'b0;
        end
        else if (mb_fire && st_r == M_BC)
        begin
            dcnt_r <= rx.data;
            rem_r <= qty_r;
            waddr_r <= sa_r;
            ph_r <= 1'b0;
        end
        else if (data_beat)
        begin
            dcnt_r <= 8'(dcnt_r - 8'h01);
            hi_r <= rx.data;
            ph_r <= !ph_r;
            if (is_coils)
            begin
                rem_r <= 16'(rem_r - coil_step);
                waddr_r <= 16'(waddr_r + 16'd8);
            end
            else if (ph_r)
                waddr_r <= 16'(waddr_r + 16'd1);
        end
    end

    // Writes leave on flops; count was checked before any data arrived
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            coil_wr <= '0;
            reg_wr <= '0;
        end
        else
        begin
            coil_wr <= '{data_beat && is_coils, waddr_r, rx.data, coil_mask};
            reg_wr <= '{data_beat && !is_coils && ph_r, waddr_r, {hi_r, rx.data}};
        end
    end

    // ------------------------------------------------------------
    // Character command path
    // ------------------------------------------------------------
    logic [7:0] cbuf_r [HDR_CHARS];
    logic [4:0] idx_r;
    logic [15:0] val_r;
    logic vbad_r;
    logic ovf_r;
    logic [15:0] aux_r;

    wire is_cr = (rx.data == CH_CR);
    wire as_end = as_fire && is_cr;

    // Collect header characters, shift the value field in as nibbles
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idx_r <= 5'd0;
            val_r <= 16'h0000;
            vbad_r <= 1'b0;
            ovf_r <= 1'b0;
        end
        else if (as_end)
        begin
            idx_r <= 5'd0;
            val_r <= 16'h0000;
            vbad_r <= 1'b0;
            ovf_r <= 1'b0;
        end
        else if (as_fire)
        begin
            if (idx_r < CMD_MAX)
                idx_r <= 5'(idx_r + 5'd1);
            else
                ovf_r <= 1'b1;
            if (idx_r >= HDR_CHARS)
            begin
                val_r <= {val_r[11:0], hex_val(rx.data)};
                vbad_r <= vbad_r || !hex_ok(rx.data);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < HDR_CHARS; g++)
        begin : g_cbuf
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    cbuf_r[g] <= 8'h00;
                else if (as_fire && !is_cr && idx_r == 5'(g))
                    cbuf_r[g] <= rx.data;
            end
        end
    endgenerate

    // Decode at the carriage return; lowercase d is taken, other lowercase falls out as invalid or, in the address, silent
    wire lead_ok = (cbuf_r[0] == CH_DOLLAR) || (cbuf_r[0] == CH_HASH);
    wire addr_hex = (idx_r >= 5'd3) && hex_ok(cbuf_r[1]) && hex_ok(cbuf_r[2]);
    wire addr_me = ({hex_val(cbuf_r[1]), hex_val(cbuf_r[2])} == STATION);
    wire silent = ovf_r || !lead_ok || !addr_hex || !addr_me;
    wire q_name = (cbuf_r[0] == CH_DOLLAR) && (idx_r == 5'd4) && (cbuf_r[3] == CH_M);
    wire q_fw = (cbuf_r[0] == CH_DOLLAR) && (idx_r == 5'd4) && (cbuf_r[3] == CH_F);
    wire sel_all = (cbuf_r[5] == CH_0) && (cbuf_r[6] == CH_0) &&
        (cbuf_r[7] == CH_0) && (cbuf_r[8] == CH_0);
    wire sel_one = (cbuf_r[5] == CH_1) && (cbuf_r[6] == CH_0) &&
        (cbuf_r[7] == CH_0) && hex_ok(cbuf_r[8]);
    wire w_flags = (cbuf_r[0] == CH_HASH) && (cbuf_r[3] == CH_V) &&
        (cbuf_r[4] == CH_D_LO || cbuf_r[4] == CH_D_UP) &&
        (idx_r > HDR_CHARS) && !vbad_r && (sel_all || sel_one);
    wire do_write = as_end && !silent && w_flags;
    wire [3:0] flag_no = hex_val(cbuf_r[8]);

    // Flag store
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            aux_r <= AUX_RESET;
        else if (do_write && sel_all)
            aux_r <= val_r;
        else if (do_write)
            aux_r[flag_no] <= val_r[0];
    end
    assign aux_flags = aux_r;

    // ------------------------------------------------------------
    // Reply framing
    // ------------------------------------------------------------
    wire [7:0] a_hi = nib_asc(STATION[7:4]);
    wire [7:0] a_lo = nib_asc(STATION[3:0]);
    wire [7:0] delim = (q_name || q_fw) ? CH_BANG : (w_flags ? CH_GT : CH_QUEST);
    wire [23:0] hdr = {a_lo, a_hi, delim};
    wire [31:0] model_txt = {nib_asc(MODEL_ID[3:0]), nib_asc(MODEL_ID[7:4]),
        nib_asc(MODEL_ID[11:8]), nib_asc(MODEL_ID[15:12])};
    wire [31:0] fw_txt = {FW_TEXT[7:0], FW_TEXT[15:8], FW_TEXT[23:16], FW_TEXT[31:24]};
    wire [63:0] mb_vec = {16'h0000, qty_r[7:0], qty_r[15:8], sa_r[7:0], sa_r[15:8],
        func_r, STATION};

    assign resp_start = mb_done || (as_end && !silent);
    assign resp_vec = !proto_ascii ? mb_vec :
        q_name ? {CH_CR, model_txt, hdr} :
        q_fw ? {CH_CR, fw_txt, hdr} :
        {32'h0000_0000, CH_CR, hdr};
    assign resp_len = !proto_ascii ? LEN_ECHO :
        (q_name || q_fw) ? LEN_LONG : LEN_SHORT;

    resp_sender #(
        .DEPTH(RESP_DEPTH)
    ) u_sender (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(resp_start),
        .load_bytes(resp_vec),
        .load_len(resp_len),
        .busy(tx_busy),
        .tx(tx),
        .tx_ready(tx_ready)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_mask_packed;
        @(posedge sys_clk) disable iff (!rst_n)
        coil_wr.valid |-> coil_wr.mask[0] && ((coil_wr.mask & 8'(coil_wr.mask + 8'h01)) == 8'h00);
    endproperty
    a_mask_packed: assert property (p_mask_packed) else $error("coil mask not low-packed");

    property p_coil_step;
        @(posedge sys_clk) disable iff (!rst_n)
        coil_wr.valid ##1 coil_wr.valid |-> coil_wr.addr == 16'($past(coil_wr.addr) + 16'd8);
    endproperty
    a_coil_step: assert property (p_coil_step) else $error("coil address step wrong");

    property p_bc_drop;
        @(posedge sys_clk) disable iff (!rst_n)
        mb_fire && st_r == M_BC && !bc_ok && !rx.last |=> st_r == M_SKIP && !coil_wr.valid;
    endproperty
    a_bc_drop: assert property (p_bc_drop) else $error("bad byte count accepted");

    sequence s_echo_load;
        mb_done ##1 tx.valid && tx.data == STATION;
    endsequence
    property p_echo;
        @(posedge sys_clk) disable iff (!rst_n)
        mb_done |-> s_echo_load ##0 (u_sender.len_r == LEN_ECHO);
    endproperty
    a_echo: assert property (p_echo) else $error("echo reply not framed");

    property p_foreign_silent;
        @(posedge sys_clk) disable iff (!rst_n)
        as_end && (!addr_me || ovf_r) |=> !tx_busy;
    endproperty
    a_foreign_silent: assert property (p_foreign_silent) else $error("reply to foreign address");

    property p_invalid_reply;
        @(posedge sys_clk) disable iff (!rst_n)
        as_end && !silent && !q_name && !q_fw && !w_flags
            |=> tx.data == CH_QUEST && u_sender.len_r == LEN_SHORT;
    endproperty
    a_invalid_reply: assert property (p_invalid_reply) else $error("invalid reply wrong");

    property p_name_reply;
        @(posedge sys_clk) disable iff (!rst_n)
        as_end && !silent && q_name |=> tx.data == CH_BANG ##0 tx_busy[*8];
    endproperty
    a_name_reply: assert property (p_name_reply) else $error("name reply wrong");

    property p_flag_write;
        @(posedge sys_clk) disable iff (!rst_n)
        do_write && sel_all |=> aux_r == $past(val_r) && tx.data == CH_GT;
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("flag write not applied");

endmodule

`default_nettype wire

// *** core/io_cmd_pkg.sv ***
// Purpose: Shared constants, types and helpers for the I/O module command parser.
// Assumes: One byte per cycle at most on the request side; ASCII hex in uppercase.
// Notes: Byte 0 of a response vector sits in bits [7:0].
// Behaviour
// - Coil force request: station, 0F, start hi/lo, quantity hi/lo, byte count, packed bytes.
// - First data byte LSB is start coil; addresses ascend; spare top bits ignored.
// - Coil force reply echoes station, function, start and quantity, no data.
// - Register preset request: station, 10, start, quantity, byte count, two bytes per register.
// - Register preset reply echoes station, function, start and quantity, no data.
// - Every character command and reply ends in one carriage return.
// - Two hex address characters follow the delimiter; this module answers at 01.
// - Valid name or version reply starts with exclamation mark and own address.
// - Well-formed invalid command gets question mark, address, carriage return.
// - Syntax error, comms error or foreign address gets no reply at all.
// - Name query is dollar, address, M; reply carries model number in hex.
// - Version query is dollar, address, F; reply carries version text then return.
// - Flag write is hash, address, opcode, four-character selector, hex value.
// - Selector 0000 writes all flags; leading 1 writes the one flag numbered.
// - Each value character holds four flags; the field covers all sixteen.
// - Accepted flag write is answered with greater-than, address, carriage return.

package io_cmd_pkg;

    // ------------------------------------------------------------
    // Codes and characters
    // ------------------------------------------------------------
    localparam logic [7:0] MY_ADDR = 8'h01;
    localparam logic [7:0] FC_COILS = 8'h0F;
    localparam logic [7:0] FC_REGS = 8'h10;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_DOLLAR = 8'h24;
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_BANG = 8'h21;
    localparam logic [7:0] CH_QUEST = 8'h3F;
    localparam logic [7:0] CH_GT = 8'h3E;
    localparam logic [7:0] CH_M = 8'h4D;
    localparam logic [7:0] CH_F = 8'h46;
    localparam logic [7:0] CH_V = 8'h56;
    localparam logic [7:0] CH_D_LO = 8'h64;
    localparam logic [7:0] CH_D_UP = 8'h44;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_1 = 8'h31;

    // ------------------------------------------------------------
    // Sizes, counts and reset values
    // ------------------------------------------------------------
    localparam int RESP_DEPTH = 8;
    localparam logic [3:0] LEN_ECHO = 4'd6;
    localparam logic [3:0] LEN_LONG = 4'd8;
    localparam logic [3:0] LEN_SHORT = 4'd4;
    localparam logic [4:0] HDR_CHARS = 5'd9;
    localparam logic [4:0] CMD_MAX = 5'd17;
    localparam logic [15:0] AUX_RESET = 16'h0000;

    typedef enum logic [3:0] {
        M_ADDR = 4'b0000,
        M_FUNC = 4'b0001,
        M_SAH = 4'b0011,
        M_SAL = 4'b0010,
        M_QH = 4'b0110,
        M_QL = 4'b0111,
        M_BC = 4'b0101,
        M_DATA = 4'b0100,
        M_SKIP = 4'b1100
    } mb_state_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } byte_beat_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] bits;
        logic [7:0] mask;
    } coil_wr_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
    } reg_wr_t;

    // Uppercase hex digits only
    function automatic logic hex_ok(input logic [7:0] c);
        return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
    endfunction

    function automatic logic [3:0] hex_val(input logic [7:0] c);
        return (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'd9);
    endfunction

    function automatic logic [7:0] nib_asc(input logic [3:0] n);
        return (n < 4'd10) ? {4'h3, n} : {4'h4, 4'(n - 4'd9)};
    endfunction

endpackage

// *** core/resp_sender.sv ***
// Purpose: Holds one framed reply and streams it out byte by byte.
// Assumes: Load only while idle; sink may stall with ready.
// Notes: Busy from the load edge until the last byte is taken.
`timescale 1ns/1ps
`default_nettype none

module resp_sender
    import io_cmd_pkg::*;
#(
    parameter int DEPTH = RESP_DEPTH
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [8*DEPTH-1:0] load_bytes,
    input wire logic [3:0] load_len,
    output logic busy,
    output byte_beat_t tx,
    input wire logic tx_ready
);

    logic [7:0] buf_r [DEPTH];
    logic [3:0] len_r;
    logic [3:0] idx_r;
    logic busy_r;
    wire tx_fire = busy_r && tx_ready;
    wire at_last = (idx_r == 4'(len_r - 4'd1));

    // ------------------------------------------------------------
    // Storage, loaded whole so the parser may clear its decode state at once
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_buf
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    buf_r[g] <= 8'h00;
                else if (start)
                    buf_r[g] <= load_bytes[8*g +: 8];
            end
        end
    endgenerate

    // Sequencing
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_r <= 1'b0;
            idx_r <= 4'd0;
            len_r <= 4'd0;
        end
        else if (start)
        begin
            busy_r <= 1'b1;
            idx_r <= 4'd0;
            len_r <= load_len;
        end
        else if (tx_fire)
        begin
            busy_r <= !at_last;
            idx_r <= 4'(idx_r + 4'd1);
        end
    end

    assign busy = busy_r;
    assign tx.valid = busy_r;
    assign tx.last = busy_r && at_last;
    assign tx.data = buf_r[idx_r[2:0]];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_start_busy;
        @(posedge sys_clk) disable iff (!rst_n)
        start |=> busy_r && idx_r == 4'd0 && len_r == $past(load_len);
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("sender not loaded");

    property p_last_ends;
        @(posedge sys_clk) disable iff (!rst_n)
        tx_fire && tx.last |=> !busy_r;
    endproperty
    a_last_ends: assert property (p_last_ends) else $error("sender ran past end");

endmodule

`default_nettype wire

// *** dv/host_model.sv ***
// Purpose: Remote host that sends whole request frames and gathers reply bytes.
// Assumes: Requests are handed to send as right-aligned byte vectors.
// Notes: With slow high the reply sink stalls on every other cycle.
`timescale 1ns/1ps
`default_nettype none

module host_model
    import io_cmd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic slow,
    output byte_beat_t rx,
    input wire logic rx_ready,
    input wire byte_beat_t tx,
    output logic tx_ready
);
    logic [8:0] got[$];

    initial rx = '0;

    // --------------------------------------------------------
    // Reply sink
    // --------------------------------------------------------
    // Stalling keeps the sender's hold logic honest
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_ready <= 1'b1;
        end
        else
        begin
            if (tx.valid && tx_ready)
            begin
                got.push_back({tx.last, tx.data});
            end
            tx_ready <= slow ? !tx_ready : 1'b1;
        end
    end

    // --------------------------------------------------------
    // Request driver
    // --------------------------------------------------------
    // Byte held until an edge sees rx_ready high; idle data inverted
    task automatic send(input logic [159:0] req, input int len);
        logic [7:0] b;
        b = 8'h00;
        @(posedge sys_clk);
        for (int i = 0; i < len; i++)
        begin
            b = req[8*(len-1-i)+:8];
            rx <= '{valid: 1'b1, last: (i == len - 1), data: b};
            @(posedge sys_clk);
            while (rx_ready !== 1'b1)
            begin
                @(posedge sys_clk);
            end
        end
        rx <= '{valid: 1'b0, last: 1'b0, data: ~b};
    endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the command parser, table driven.
// Assumes: Model id and version text are set here to arbitrary values.
// Notes: Coil and register pulses are gathered over the whole run.
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import io_cmd_pkg::*;
;
    typedef struct {
        bit asc;
        bit stall;
        int rlen;
        logic [159:0] req;
        int elen;
        logic [127:0] exp;
        logic [15:0] flg;
    } row_t;

    logic sys_clk;
    logic rst_n;
    logic proto_ascii;
    logic slow;
    byte_beat_t rx;
    logic rx_ready;
    byte_beat_t tx;
    logic tx_ready;
    coil_wr_t coil_wr;
    reg_wr_t reg_wr;
    logic [15:0] aux_flags;
    int n_fail = 0;
    int compares = 0;
    row_t rows[$];
    logic [31:0] coil_seen[$];
    logic [31:0] reg_seen[$];

    io_module_command_parser #(
        .STATION(MY_ADDR),
        .MODEL_ID(16'hA5C3), // Arbitrary value
        .FW_TEXT(32'h322E_3035) // Arbitrary value
    ) io_module_command_parser_i (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .proto_ascii(proto_ascii),
        .rx(rx),
        .rx_ready(rx_ready),
        .tx(tx),
        .tx_ready(tx_ready),
        .coil_wr(coil_wr),
        .reg_wr(reg_wr),
        .aux_flags(aux_flags)
    );

    host_model host_model_i (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .slow(slow),
        .rx(rx),
        .rx_ready(rx_ready),
        .tx(tx),
        .tx_ready(tx_ready)
    );

    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;

    // Write pulses kept in order for the end check
    always @(posedge sys_clk)
    begin
        if (coil_wr.valid === 1'b1)
            coil_seen.push_back({coil_wr.addr, coil_wr.bits, coil_wr.mask});
        if (reg_wr.valid === 1'b1)
            reg_seen.push_back({reg_wr.addr, reg_wr.data});
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        if (n_fail == 0 && compares > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Bounded wait, then a few idle edges so stray bytes show up
    task automatic run_row(input row_t r);
        host_model_i.got.delete();
        proto_ascii <= r.asc;
        slow <= r.stall;
        host_model_i.send(r.req, r.rlen);
        for (int k = 0; k < 60 && host_model_i.got.size() < r.elen; k++)
            @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        check("reply length", 32'(host_model_i.got.size()), 32'(r.elen));
        // Each character reply ends on its own CR, so two replies flag last twice
        for (int k = 0; k < r.elen; k++)
            check("reply byte", {23'b0, host_model_i.got[k]},
                {23'b0, (k == r.elen - 1 || (r.asc && r.exp[8*(r.elen-1-k)+:8] == CH_CR)),
                    r.exp[8*(r.elen-1-k)+:8]});
        check("aux flags", {16'h0000, aux_flags}, {16'h0000, r.flg});
    endtask

    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        proto_ascii = 1'b0;
        slow = 1'b0;
        rows.push_back('{0, 0, 9, 72'h010F_0011_000A_02CD_01, 6, 48'h010F_0011_000A, 0});
        rows.push_back('{0, 1, 11, 88'h0110_0009_0002_0442_C800_00, 6, 48'h0110_0009_0002, 0});
        rows.push_back('{0, 0, 8, 64'h010F_0011_000A_01CD, 0, 8'h00, 0});
        rows.push_back('{0, 0, 9, 72'h0210_0009_0001_0212_34, 0, 8'h00, 0});
        rows.push_back('{1, 0, 5, "$01M\015", 8, "!01A5C3\015", 0});
        rows.push_back('{1, 1, 10, "$01F\015$01X\015", 12, "!012.05\015?01\015", 0});
        rows.push_back('{1, 0, 5, "$02M\015", 0, 8'h00, 0});
        rows.push_back('{1, 0, 5, "$01m\015", 4, "?01\015", 0});
        rows.push_back('{1, 0, 5, "!01M\015", 0, 8'h00, 0});
        rows.push_back('{1, 1, 14, "#01Vd0000FFFF\015", 4, ">01\015", 16'hFFFF});
        rows.push_back('{1, 0, 14, "#01Vd10030000\015", 4, ">01\015", 16'hFFF7});
        rows.push_back('{1, 0, 14, "#01VD0000002B\015", 4, ">01\015", 16'h002B});
        rows.push_back('{1, 1, 11, "#01Vd10021\015", 4, ">01\015", 16'h002F});
        rows.push_back('{1, 0, 14, "#01Vd100E0001\015", 4, ">01\015", 16'h402F});
        // Non-hex value, then the longest legal command, then one character too many
        rows.push_back('{1, 0, 14, "#01Vd0000FFGF\015", 4, "?01\015", 16'h402F});
        rows.push_back('{1, 0, 18, "#01Vd000000001234\015", 4, ">01\015", 16'h1234});
        rows.push_back('{1, 0, 19, "#01Vd0000000005678\015", 0, 8'h00, 16'h1234});
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (rows[i])
            run_row(rows[i]);
        // Coil bits land LSB first; the short count frame wrote nothing
        check("coil pulses", 32'(coil_seen.size()), 32'd2);
        check("coil pulse 0", coil_seen[0], 32'h0011_CDFF);
        check("coil pulse 1", coil_seen[1], 32'h0019_0103);
        check("reg pulses", 32'(reg_seen.size()), 32'd2);
        check("reg pulse 0", reg_seen[0], 32'h0009_42C8);
        check("reg pulse 1", reg_seen[1], 32'h000A_0000);
        // Reset while a stalled reply drains, then a clean query
        slow <= 1'b1;
        proto_ascii <= 1'b1;
        host_model_i.send("$01F\015", 5);
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check("tx valid in reset", {31'b0, tx.valid}, 32'd0);
        check("rx ready in reset", {31'b0, rx_ready}, 32'd1);
        check("flags in reset", {16'h0000, aux_flags}, 32'h0000_0000);
        rst_n <= 1'b1;
        run_row(rows[4]);
        final_report();
    end

    // Whole run needs a few hundred cycles; this is far beyond it
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
